// ==== design/asws_map.vh ====
// Register map, field positions, reset values and rate constants of the sequencer.
`ifndef ASWS_MAP_VH
`define ASWS_MAP_VH

// Register indices; the byte address is four times the index.
`define ASWS_IDX_PIN_SEL      5'h08
`define ASWS_IDX_CTRL         5'h09
`define ASWS_IDX_RESULT       5'h0B
`define ASWS_IDX_RESULT_HI    5'h0C
`define ASWS_IDX_RESULT_LO    5'h0D
`define ASWS_IDX_STATUS       5'h0E
`define ASWS_IDX_IRQ_CTRL     5'h10

// Field positions in the converter control register.
`define ASWS_CTRL_REF_BIT     7
`define ASWS_CTRL_RATE_HI     6
`define ASWS_CTRL_RATE_LO     5
`define ASWS_CTRL_RUN_BIT     4
`define ASWS_CTRL_POWER_BIT   3
`define ASWS_CTRL_CHAN_HI     1
`define ASWS_CTRL_CHAN_LO     0

// Field positions in the status and interrupt control registers.
`define ASWS_STAT_DONE_BIT    5
`define ASWS_STAT_WAKE_BIT    3
`define ASWS_IRQC_EN_BIT      3

// Reset values.
`define ASWS_PIN_SEL_RST      4'h0
`define ASWS_CTRL_RST         8'h00
`define ASWS_RESULT_RST       12'h000

// Conversion clock rate codes and the matching divider terminal counts.
`define ASWS_RATE_DIV16       2'h0
`define ASWS_RATE_DIV4        2'h1
`define ASWS_RATE_DIV64       2'h2
`define ASWS_RATE_RC          2'h3
`define ASWS_TC_DIV16         6'h0F
`define ASWS_TC_DIV4          6'h03
`define ASWS_TC_DIV64         6'h3F

// Converter width and the completion interrupt vector.
`define ASWS_RES_BITS         12
`define ASWS_IRQ_VECTOR       12'h00C

`endif

// ==== design/asws_rate_div.v ====
// Conversion bit-time tick generator with selectable divider or RC source.
`timescale 1ns/10ps
module asws_rate_div (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       run_i,
  input  wire [1:0] rate_i,
  input  wire       rc_edge_i,
  output wire       tick_o
);
`include "asws_map.vh"

  reg  [5:0] cnt_reg;
  reg  [5:0] terminal;
  reg        tick_reg;

  // Picks the terminal count for the selected divider.
  always @* begin
    case (rate_i)
      `ASWS_RATE_DIV16: terminal = `ASWS_TC_DIV16;
      `ASWS_RATE_DIV4:  terminal = `ASWS_TC_DIV4;
      `ASWS_RATE_DIV64: terminal = `ASWS_TC_DIV64;
      default:          terminal = `ASWS_TC_DIV16;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // rate select divider.
  // Counter restarts whenever no conversion runs, so every bit time is whole.
  always @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_reg  <= 6'h00;
      tick_reg <= 1'b0;
    end else if (rate_i == `ASWS_RATE_RC) begin
      // Hold off the first RC edge until the synchronised comparator has seen the new trial.
      if (cnt_reg != `ASWS_TC_DIV4) begin
        cnt_reg <= cnt_reg + 6'h01;
      end
      tick_reg <= rc_edge_i && (cnt_reg == `ASWS_TC_DIV4);
    end else if (cnt_reg >= terminal) begin
      cnt_reg  <= 6'h00;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg + 6'h01;
      tick_reg <= 1'b0;
    end
  end

  assign tick_o = tick_reg;

endmodule

// ==== design/asws_sar.v ====
// Successive-approximation bit sequencer driving the trial code.
`timescale 1ns/10ps
module asws_sar (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        start_i,
  input  wire        tick_i,
  input  wire        cmp_i,
  output wire        busy_o,
  output wire        done_o,
  output wire [11:0] code_o
);
`include "asws_map.vh"

  reg        busy_reg;
  reg        done_reg;
  reg [11:0] code_reg;
  reg [3:0]  bit_reg;

  // Trial and keep one bit per tick, most significant first.
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      code_reg <= `ASWS_RESULT_RST;
      bit_reg  <= 4'h0;
    end else begin
      done_reg <= 1'b0;
      if (!busy_reg) begin
        if (start_i) begin
          busy_reg <= 1'b1;
          bit_reg  <= 4'hB;
          code_reg <= 12'h800;
        end
      end else if (tick_i) begin
        // A low comparator means the trial overshot; drop the trial bit.
        if (!cmp_i) begin
          code_reg[bit_reg] <= 1'b0;
        end
        if (bit_reg == 4'h0) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          bit_reg                  <= bit_reg - 4'h1;
          code_reg[bit_reg - 4'h1] <= 1'b1;
        end
      end
    end
  end

  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign code_o = code_reg;

endmodule

// ==== design/asws_top.v ====
// Converter control, completion and sleep wake sequencer with Avalon-MM registers.
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/10ps
module asws_top (
  input  wire        clk_i,
  input  wire        rst_i,
  // Avalon-MM slave.
  input  wire [6:0]  address_i,
  input  wire        read_i,
  input  wire        write_i,
  input  wire [31:0] writedata_i,
  input  wire [3:0]  byteenable_i,
  output wire [31:0] readdata_o,
  output wire        waitrequest_o,
  // Core side.
  input  wire        core_sleep_i,
  input  wire        global_irq_en_i,
  output wire        wake_o,
  output wire        resume_next_o,
  output wire        irq_req_o,
  output wire [11:0] irq_vector_o,
  // Analog front end.
  input  wire        comparator_i,
  input  wire        rc_osc_i,
  output wire [11:0] dac_code_o,
  output wire [1:0]  channel_o,
  output wire        converter_power_on_o,
  output wire        reference_source_select_o,
  output wire [3:0]  pin_analog_enable_o
);
`include "asws_map.vh"

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  reg  [3:0]  pin_sel_reg;
  reg         ref_sel_reg;
  reg  [1:0]  rate_reg;
  reg         run_reg;
  reg         power_reg;
  reg  [1:0]  chan_reg;
  reg         done_flag_reg;
  reg         wake_en_reg;
  reg         irq_en_reg;
  reg         shut_reg;
  reg  [11:0] result_reg;
  reg         ack_reg;
  reg  [31:0] rdata_reg;
  reg  [31:0] rdata_next;
  reg         wake_reg;
  reg         resume_reg;
  reg         cmp_meta_reg;
  reg         cmp_sync_reg;
  reg         rc_meta_reg;
  reg         rc_sync_reg;
  reg         rc_prev_reg;
  wire [4:0]  idx;
  wire        wr_ok;
  wire        wr_pin;
  wire        wr_ctrl;
  wire        wr_stat;
  wire        wr_irqc;
  wire        done_evt;
  wire        sar_busy;
  wire [11:0] sar_code;
  wire        tick;
  wire        rc_edge;
  wire        start_conv;
  wire        power_eff;
  wire        chan_change;
  wire        wake_cond;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: every access stalls one cycle, then completes.
  assign idx     = address_i[6:2];
  assign wr_ok   = write_i && ack_reg && byteenable_i[0];
  assign wr_pin  = wr_ok && (idx == `ASWS_IDX_PIN_SEL);
  assign wr_ctrl = wr_ok && (idx == `ASWS_IDX_CTRL);
  assign wr_stat = wr_ok && (idx == `ASWS_IDX_STATUS);
  assign wr_irqc = wr_ok && (idx == `ASWS_IDX_IRQ_CTRL);

  assign waitrequest_o = (read_i || write_i) && !ack_reg;

  // Acknowledge toggles so that back-to-back requests each stall once.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read_i || write_i) && !ack_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers; only the second stage, and for the RC pin the third, feeds logic.
  always @(posedge clk_i) begin
    if (rst_i) begin
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
      rc_meta_reg  <= 1'b0;
      rc_sync_reg  <= 1'b0;
      rc_prev_reg  <= 1'b0;
    end else begin
      cmp_meta_reg <= comparator_i;
      cmp_sync_reg <= cmp_meta_reg;
      rc_meta_reg  <= rc_osc_i;
      rc_sync_reg  <= rc_meta_reg;
      rc_prev_reg  <= rc_sync_reg;
    end
  end

  // Rising edge of the synchronised RC oscillator is one bit time.
  assign rc_edge = rc_sync_reg && !rc_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion engine and its bit-time source.
  // forced shut-off overrides power bit.
  assign power_eff  = power_reg && !shut_reg;
  // conversion ignores core sleep.
  // A conversion starts only once powered; the done cycle cannot restart it.
  assign start_conv = run_reg && power_eff && !sar_busy && !done_evt;

  asws_rate_div u_rate_div (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .run_i     (sar_busy),
    .rate_i    (rate_reg),
    .rc_edge_i (rc_edge),
    .tick_o    (tick)
  );

  asws_sar u_sar (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (start_conv),
    .tick_i  (tick),
    .cmp_i   (cmp_sync_reg),
    .busy_o  (sar_busy),
    .done_o  (done_evt),
    .code_o  (sar_code)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin analog enables and the configuration fields of the control register.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_sel_reg <= `ASWS_PIN_SEL_RST;
      ref_sel_reg <= 1'b0;
      rate_reg    <= `ASWS_RATE_DIV16;
      power_reg   <= 1'b0;
    end else begin
      if (wr_pin) begin
        pin_sel_reg <= writedata_i[3:0];
      end
      // Rate and reference change only between conversions.
      if (wr_ctrl) begin
        power_reg <= writedata_i[`ASWS_CTRL_POWER_BIT];
        if (!sar_busy) begin
          ref_sel_reg <= writedata_i[`ASWS_CTRL_REF_BIT];
          rate_reg    <= writedata_i[`ASWS_CTRL_RATE_HI:`ASWS_CTRL_RATE_LO];
        end
      end
    end
  end

  // A differing channel write while idle and done clears the result; the channel stays as it is.
  assign chan_change = wr_ctrl && !run_reg && done_flag_reg &&
                       (writedata_i[`ASWS_CTRL_CHAN_HI:`ASWS_CTRL_CHAN_LO] != chan_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Channel select.
  always @(posedge clk_i) begin
    if (rst_i) begin
      chan_reg <= 2'h0;
    end else begin
      if (wr_ctrl && !done_flag_reg && !run_reg) begin
        chan_reg <= writedata_i[`ASWS_CTRL_CHAN_HI:`ASWS_CTRL_CHAN_LO];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run bit: a software set wins over a completion clear in the same cycle.
  always @(posedge clk_i) begin
    if (rst_i) begin
      run_reg <= 1'b0;
    end else begin
      if (wr_ctrl && writedata_i[`ASWS_CTRL_RUN_BIT]) begin
        run_reg <= 1'b1;
      end else if (done_evt) begin
        run_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flag and enables; the hardware set beats a software clear.
  always @(posedge clk_i) begin
    if (rst_i) begin
      done_flag_reg <= 1'b0;
      wake_en_reg   <= 1'b0;
      irq_en_reg    <= 1'b0;
    end else begin
      if (done_evt) begin
        done_flag_reg <= 1'b1;
      end else if (wr_stat) begin
        done_flag_reg <= writedata_i[`ASWS_STAT_DONE_BIT];
      end
      if (wr_stat) begin
        wake_en_reg <= writedata_i[`ASWS_STAT_WAKE_BIT];
      end
      if (wr_irqc) begin
        irq_en_reg <= writedata_i[`ASWS_IRQC_EN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Forced shut-off after a silent completion in sleep.
  always @(posedge clk_i) begin
    if (rst_i) begin
      shut_reg <= 1'b0;
    end else begin
      if (done_evt && core_sleep_i && !irq_en_reg) begin
        shut_reg <= 1'b1;
      end else if (wr_ctrl && writedata_i[`ASWS_CTRL_RUN_BIT]) begin
        shut_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result registers; a completion load beats a channel-change clear.
  always @(posedge clk_i) begin
    if (rst_i) begin
      result_reg <= `ASWS_RESULT_RST;
    end else begin
      if (done_evt) begin
        result_reg <= sar_code;
      end else if (chan_change) begin
        result_reg <= `ASWS_RESULT_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake and resume requests, one-cycle pulses on the completion edge.
  assign wake_cond = done_evt && core_sleep_i && (wake_en_reg || irq_en_reg);

  always @(posedge clk_i) begin
    if (rst_i) begin
      wake_reg   <= 1'b0;
      resume_reg <= 1'b0;
    end else begin
      wake_reg   <= wake_cond;
      resume_reg <= wake_cond && irq_en_reg && !global_irq_en_i;
    end
  end

  assign wake_o        = wake_reg;
  assign resume_next_o = resume_reg;

  // awake completion vectors.
  // The request stands while the done flag is set and both enables allow it.
  assign irq_req_o    = done_flag_reg && irq_en_reg && global_irq_en_i;
  assign irq_vector_o = `ASWS_IRQ_VECTOR;

  ////////////////////////////////////////////////////////////////////////////
  // Read data multiplexer; unmapped words read as zero.
  always @* begin
    rdata_next = 32'h0000_0000;
    case (idx)
      `ASWS_IDX_PIN_SEL:   rdata_next[3:0]  = pin_sel_reg;
      `ASWS_IDX_CTRL:      rdata_next[7:0]  = {ref_sel_reg, rate_reg, run_reg,
                                               power_reg, 1'b0, chan_reg};
      `ASWS_IDX_RESULT:    rdata_next[7:0]  = result_reg[11:4];
      `ASWS_IDX_RESULT_HI: rdata_next[3:0]  = result_reg[11:8];
      `ASWS_IDX_RESULT_LO: rdata_next[7:0]  = result_reg[7:0];
      `ASWS_IDX_STATUS: begin
        rdata_next[`ASWS_STAT_DONE_BIT] = done_flag_reg;
        rdata_next[`ASWS_STAT_WAKE_BIT] = wake_en_reg;
      end
      `ASWS_IDX_IRQ_CTRL:  rdata_next[`ASWS_IRQC_EN_BIT] = irq_en_reg;
      default:             rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the stall cycle and stands at the answer edge.
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (read_i && !ack_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  assign readdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Analog front-end controls.
  assign dac_code_o                = sar_code;
  assign channel_o                 = chan_reg;
  assign converter_power_on_o      = power_eff;
  assign reference_source_select_o = ref_sel_reg;
  assign pin_analog_enable_o       = pin_sel_reg;

endmodule

// ==== verification/asws_top_assertions.sv ====
// Concurrent checks on the sequencer top-level ports.
`timescale 1ns/10ps
module asws_checker (
  input wire        clk_i,
  input wire        rst_i,
  input wire        read_i,
  input wire        write_i,
  input wire        waitrequest_o,
  input wire        core_sleep_i,
  input wire        global_irq_en_i,
  input wire        wake_o,
  input wire        resume_next_o,
  input wire        irq_req_o,
  input wire [11:0] irq_vector_o,
  input wire [1:0]  channel_o,
  input wire        converter_power_on_o
);
  // All checks run on the system clock and rest during reset.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A bus access stalls for exactly one cycle.
  sequence s_one_wait;
    waitrequest_o ##1 !waitrequest_o;
  endsequence
  // A wake is a lone one-cycle pulse.
  sequence s_wake_pulse;
    wake_o ##1 !wake_o;
  endsequence
  chk_bus_one_wait: assert property ($rose(read_i || write_i) |-> s_one_wait)
    else $error("bus stall is not one cycle");
  chk_wake_single: assert property (wake_o |-> s_wake_pulse)
    else $error("wake pulse longer than one cycle");
  chk_wake_sleep: assert property (wake_o |-> $past(core_sleep_i))
    else $error("wake raised while core awake");
  chk_resume_next: assert property (resume_next_o |-> wake_o && !$past(global_irq_en_i))
    else $error("resume without wake or with globals on");
  chk_irq_global: assert property (irq_req_o |-> global_irq_en_i)
    else $error("interrupt request with globals off");
  chk_vector_fixed: assert property (irq_vector_o == 12'h00C)
    else $error("interrupt vector wrong");
  chk_chan_write: assert property ($changed(channel_o) |-> $past(write_i) && !$past(waitrequest_o))
    else $error("channel changed without a bus write");
  chk_power_rise: assert property ($rose(converter_power_on_o) |-> $past(write_i))
    else $error("converter powered without a write");
  chk_power_drop: assert property ($fell(converter_power_on_o) && !$past(write_i) |-> !irq_req_o && !resume_next_o)
    else $error("shut-off while interrupt enabled");
endmodule

// ==== verification/asws_afe_model.sv ====
// Behavioural analog front end: comparator against a held level and a slow RC clock.
`timescale 1ns/10ps
module asws_afe_model (
  input  wire        clk_i,
  input  wire [11:0] level_i,
  input  wire [11:0] dac_code_i,
  output wire        comparator_o,
  output wire        rc_osc_o
);
  logic [2:0] div_reg = 3'h0;
  logic       rc_reg  = 1'b0;
  // input held steady
  // The comparator reports one while the held input is at or above the trial code.
  assign comparator_o = (level_i >= dac_code_i);
  assign rc_osc_o     = rc_reg;
  // The oscillator runs free, one full period every sixteen system clocks.
  always @(posedge clk_i) begin
    div_reg <= div_reg + 3'h1;
    if (div_reg == 3'h7)
      rc_reg <= ~rc_reg;
  end
endmodule

// ==== verification/tb_adc_sleep_wake_sequencer.sv ====
// Self-checking bench for the sequencer: registers, conversions, sleep and wake.
`timescale 1ns/10ps
`include "asws_map.vh"
module tb_adc_sleep_wake_sequencer;
  localparam logic [6:0] A_PIN = {`ASWS_IDX_PIN_SEL, 2'b00};
  localparam logic [6:0] A_CTL = {`ASWS_IDX_CTRL, 2'b00};
  localparam logic [6:0] A_RES = {`ASWS_IDX_RESULT, 2'b00};
  localparam logic [6:0] A_RHI = {`ASWS_IDX_RESULT_HI, 2'b00};
  localparam logic [6:0] A_RLO = {`ASWS_IDX_RESULT_LO, 2'b00};
  localparam logic [6:0] A_STA = {`ASWS_IDX_STATUS, 2'b00};
  localparam logic [6:0] A_IRQ = {`ASWS_IDX_IRQ_CTRL, 2'b00};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [6:0]  address_i = 7'h00;
  logic        read_i = 1'b0;
  logic        write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic [3:0]  byteenable_i = 4'hF;
  logic        core_sleep_i = 1'b0;
  logic        global_irq_en_i = 1'b0;
  logic [11:0] level = 12'h000;
  wire  [31:0] readdata_o;
  wire  [11:0] irq_vector_o, dac_code_o;
  wire  [3:0]  pin_analog_enable_o;
  wire  [1:0]  channel_o;
  wire         waitrequest_o, wake_o, resume_next_o, irq_req_o, cmp_w, rc_w, pwr_w, ref_w;
  int          failures = 0;
  int          checked = 0;
  int          n;
  int          cyc = 0;
  int          t0;
  int          bt [4] = '{16, 4, 64, 16}; // Clocks per bit time; RC is the model's period.
  integer      seed = 9280;
  logic [15:0] rq[$];
  logic        wq[$];
  logic [15:0] note;
  logic [7:0]  rd, cfg;
  logic [6:0]  addrs [8] = '{A_PIN, A_CTL, A_RES, A_RHI, A_RLO, A_STA, A_IRQ, 7'h7C};

  asws_top u_asws_top (
    .clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .core_sleep_i(core_sleep_i),
    .global_irq_en_i(global_irq_en_i), .wake_o(wake_o), .resume_next_o(resume_next_o),
    .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o), .comparator_i(cmp_w),
    .rc_osc_i(rc_w), .dac_code_o(dac_code_o), .channel_o(channel_o),
    .converter_power_on_o(pwr_w), .reference_source_select_o(ref_w),
    .pin_analog_enable_o(pin_analog_enable_o));
  asws_afe_model u_asws_afe_model (.clk_i(clk_i), .level_i(level),
    .dac_code_i(dac_code_o), .comparator_o(cmp_w), .rc_osc_o(rc_w));

  // System clock at 200 MHz.
  always #2.5 clk_i = ~clk_i;

  // Free-running cycle count used to time conversions.
  always @(posedge clk_i) cyc <= cyc + 1;

  task automatic cmp(input string nm, input logic [11:0] e, input logic [11:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up;
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One bus access held until waitrequest is sampled low; reads leave a note.
  task automatic bus(input logic w, input logic [6:0] a, input logic [7:0] d,
                     input logic [3:0] be, input logic [15:0] nt);
    int k;
    k = 0;
    @(posedge clk_i);
    address_i    <= a;
    write_i      <= w;
    read_i       <= ~w;
    writedata_i  <= {24'h000000, d};
    byteenable_i <= be;
    if (!w)
      rq.push_back(nt);
    do begin
      @(posedge clk_i);
      k++;
    end while (waitrequest_o !== 1'b0 && k < 50);
    rd = readdata_o[7:0];
    if (k >= 50) begin
      failures++;
      wrap_up();
    end
    read_i  <= 1'b0;
    write_i <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1, 16'h0000);
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] e, input logic [7:0] m);
    bus(1'b0, a, 8'h00, 4'hF, {m, e});
  endtask

  // Read data is matched in order against the driver's notes.
  always @(posedge clk_i) begin
    if (read_i && waitrequest_o === 1'b0) begin
      note = rq.pop_front();
      if (note[15:8] != 8'h00)
        cmp("read data", {4'h0, note[7:0]}, {4'h0, note[15:8] & readdata_o[7:0]});
    end
  end

  // Each wake pulse is matched against the expected resume flag.
  always @(posedge clk_i) begin
    if (wake_o === 1'b1) begin
      if (wq.size() == 0)
        cmp("wake", 12'h000, 12'h001);
      else
        cmp("resume next", {11'h000, wq.pop_front()}, {11'h000, resume_next_o});
    end
  end

  // Main sequence: reset values, pin enables, then one conversion per rate code.
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (addrs[k]) rdc(addrs[k], 8'h00, 8'hFF);
    bus(1'b1, A_PIN, 8'h05, 4'h0, 16'h0000);
    rdc(A_PIN, 8'h00, 8'hFF);
    wr(A_PIN, 8'h05);
    rdc(A_PIN, 8'h05, 8'hFF);
    cmp("pin enables", 12'h005, {8'h00, pin_analog_enable_o});
    for (int i = 0; i < 4; i++) begin
      cfg = {1'b1, i[1:0], 1'b0, 1'b1, 1'b0, i[1:0]};
      level <= 12'($random(seed));
      wr(A_IRQ, {4'h0, i != 3, 3'h0});
      wr(A_STA, 8'h08);
      wr(A_CTL, cfg);
      core_sleep_i    <= (i != 0);
      global_irq_en_i <= (i != 1);
      @(negedge clk_i);
      cmp("channel", {10'h000, i[1:0]}, {10'h000, channel_o});
      cmp("reference", 12'h001, {11'h000, ref_w});
      if (i != 0)
        wq.push_back(i == 1);
      wr(A_CTL, cfg | 8'h10);
      t0 = cyc;
      wr(A_CTL, cfg);
      rdc(A_CTL, cfg | 8'h10, 8'hFF);
      n = 0;
      do begin
        rdc(A_CTL, 8'h00, 8'h00);
        n++;
      end while (rd[4] !== 1'b0 && n < 500);
      if (n >= 500) begin
        failures++;
        wrap_up();
      end
      // Twelve bit times plus start, settle and polling slack.
      cmp("bit time", 12'h001, {11'h000, (cyc - t0 >= 12 * bt[i] - 16) &&
                                        (cyc - t0 <= 12 * bt[i] + 24)});
      core_sleep_i <= 1'b0;
      rdc(A_STA, 8'h28, 8'hFF);
      rdc(A_RES, level[11:4], 8'hFF);
      rdc(A_RHI, {4'h0, level[11:8]}, 8'hFF);
      rdc(A_RLO, level[7:0], 8'hFF);
      cmp("trial code", level, dac_code_o);
      cmp("irq request", {11'h000, ~i[0]}, {11'h000, irq_req_o});
      cmp("power", {11'h000, i != 3}, {11'h000, pwr_w});
      wr(A_CTL, cfg ^ 8'h01);
      rdc(A_RES, 8'h00, 8'hFF);
      cmp("channel lock", {10'h000, i[1:0]}, {10'h000, channel_o});
      wr(A_STA, 8'h08);
      rdc(A_STA, 8'h08, 8'hFF);
      repeat (128) @(posedge clk_i);
    end
    cmp("wakes left", 12'h000, 12'(wq.size()));
    wrap_up();
  end
endmodule

bind asws_top asws_checker u_asws_checker (
  .clk_i(clk_i), .rst_i(rst_i), .read_i(read_i), .write_i(write_i),
  .waitrequest_o(waitrequest_o), .core_sleep_i(core_sleep_i),
  .global_irq_en_i(global_irq_en_i), .wake_o(wake_o), .resume_next_o(resume_next_o),
  .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o), .channel_o(channel_o),
  .converter_power_on_o(converter_power_on_o));
